// file: ext_bus_pkg.sv
/*
 * Constants and carrier types of the external bus sequencer.
 * Assumes one clock and an 8-bit register address space.
 */
`default_nettype none

package ext_bus_pkg;

    // Register byte addresses on the register bus.
    localparam logic [7:0] LOW_PORT_OFS  = 8'h80;
    localparam logic [7:0] HIGH_PORT_OFS = 8'ha0;
    localparam logic [7:0] AUX_PORT_OFS  = 8'hb0;
    localparam logic [7:0] CLK_CTRL_OFS  = 8'h84;
    localparam logic [7:0] PIN_READ_OFS  = 8'h88;

    // Values after reset.
    localparam logic [7:0] PORT_RESET     = 8'hff;
    localparam logic       X2_REQ_RESET   = 1'b0;

    // Field positions.
    localparam int X2_REQ_BIT = 0;
    localparam int X2_ACT_BIT = 1;
    localparam int WR_BIT     = 6;
    localparam int RD_BIT     = 7;

    // Machine cycle: six states, two address slots, strobe windows.
    localparam logic [2:0] LAST_STATE    = 3'h5;
    localparam logic [2:0] ST_ADDR_A     = 3'h0;
    localparam logic [2:0] ST_ADDR_B     = 3'h3;
    localparam logic [2:0] ST_FETCH_A    = 3'h2;
    localparam logic [2:0] ST_FETCH_B    = 3'h5;
    localparam logic [2:0] ST_XFER_FIRST = 3'h1;
    localparam logic [2:0] ST_XFER_LAST  = 3'h4;

    // Reset pin: machine cycles held high, and boundaries counted for it.
    localparam logic [1:0] RESET_MCYCLES = 2'h2;
    localparam logic [1:0] RESET_EDGES   = RESET_MCYCLES + 2'h1;

    typedef enum logic [1:0] {
        CYC_INT_FETCH,
        CYC_EXT_FETCH,
        CYC_DATA_RD,
        CYC_DATA_WR
    } cycle_kind_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        wide;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } xdata_req_t;

    typedef struct packed {
        logic       done;
        logic [7:0] rdata;
    } xdata_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } code_rsp_t;

endpackage

`default_nettype wire

// file: machine_phase_gen.sv
/*
 * Phase generator: optional divide-by-two and a six-state counter.
 * Assumes mclk is the crystal input and x2_req a synchronous level.
 */
`default_nettype none
`timescale 1ns/1ns

module machine_phase_gen (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       x2_req,
    output logic            tick,
    output logic [2:0]      state_cur,
    output logic [2:0]      state_nxt,
    output logic            x2_active
);

    logic       half_q;
    logic       x2_q;
    logic [2:0] state_q;

    // Divide-by-two stage; its rising edge is the edge where half_q is low.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            half_q <= 1'b0;
        end else begin
            half_q <= ~half_q;
        end
    end

    // Mode bit taken only on the divided clock's rising edge, so a switch
    // never yields a state shorter than one oscillator period.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            x2_q <= ext_bus_pkg::X2_REQ_RESET;
        end else if (!half_q) begin
            x2_q <= x2_req;
        end
    end

    // Standard mode ticks every second period, double speed every period.
    assign tick = x2_q | half_q;

    // Six states per machine cycle.
    always_comb begin
        state_nxt = state_q;
        if (tick) begin
            state_nxt = (state_q == ext_bus_pkg::LAST_STATE) ? 3'h0
                      : state_q + 3'h1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= 3'h0;
        end else begin
            state_q <= state_nxt;
        end
    end

    assign state_cur = state_q;
    assign x2_active = x2_q;

endmodule // machine_phase_gen

`default_nettype wire

// file: ext_bus_ctrl.sv
/*
 * External bus sequencer: address, fetch, read and write strobes,
 * multiplexed low port, high address port, port latches and an
 * Avalon-MM register slave.
 * Assumes synchronous pins, wire levels resolved outside from out,
 * oe_n and pull, and a core that holds a data request until done.
 */
`default_nettype none
`timescale 1ns/1ns

module ext_bus_ctrl (
    input  wire logic                     mclk,
    input  wire logic                     arst_n,
    input  wire logic                     reset_pin,
    input  wire logic                     external_code_select_n,
    input  wire logic [15:0]              fetch_addr,
    input  wire ext_bus_pkg::xdata_req_t  xdata_req,
    output ext_bus_pkg::xdata_rsp_t       xdata_rsp,
    output ext_bus_pkg::code_rsp_t        code_rsp,
    output logic                          core_reset,
    output logic                          ale,
    output logic                          program_fetch_strobe_n,
    input  wire logic [7:0]               low_port_in,
    output logic [7:0]                    low_port_out,
    output logic [7:0]                    low_port_oe_n,
    input  wire logic [7:0]               high_port_in,
    output logic [7:0]                    high_port_out,
    output logic [7:0]                    high_port_oe_n,
    output logic [7:0]                    high_port_pull,
    input  wire logic [7:0]               aux_port_in,
    output logic [7:0]                    aux_port_out,
    output logic [7:0]                    aux_port_oe_n,
    output logic [7:0]                    aux_port_pull,
    input  wire logic [7:0]               avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    output logic [31:0]                   avs_readdata,
    output logic                          avs_waitrequest
);

    logic                     tick;
    logic [2:0]               state_cur;
    logic [2:0]               state_nxt;
    logic                     x2_active;
    logic                     cycle_start;

    logic [7:0]               low_latch_q;
    logic [7:0]               high_latch_q;
    logic [7:0]               aux_latch_q;
    logic                     x2_req_q;
    logic                     wait_q;
    logic                     bus_req;
    logic                     bus_accept;
    logic [1:0]               rst_cnt_q;
    logic                     core_rst_q;

    ext_bus_pkg::cycle_kind_t kind_q;
    ext_bus_pkg::cycle_kind_t kind_d;
    ext_bus_pkg::xdata_req_t  req_q;
    ext_bus_pkg::xdata_req_t  req_d;
    logic [15:0]              addr_q;
    logic [15:0]              addr_d;

    logic                     ale_d;
    logic                     program_fetch_strobe_n_d;
    logic                     rd_n_d;
    logic                     wr_n_d;
    logic                     lp_bus;
    logic [7:0]               lp_val;
    logic                     hp_bus;
    logic [7:0]               aux_eff;

    // Phase generator; the mode request comes from the clock register.
    machine_phase_gen phase_gen (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .x2_req    (x2_req_q),
        .tick      (tick),
        .state_cur (state_cur),
        .state_nxt (state_nxt),
        .x2_active (x2_active)
    );

    assign cycle_start = tick && (state_nxt == ext_bus_pkg::ST_ADDR_A);

    // Reset pin is counted in machine cycle boundaries; three boundaries
    // guarantee two whole cycles even when the pin rises mid-cycle.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt_q  <= 2'h0;
            core_rst_q <= 1'b0;
        end else if (!reset_pin) begin
            rst_cnt_q  <= 2'h0;
            core_rst_q <= 1'b0;
        end else begin
            if (cycle_start && rst_cnt_q != ext_bus_pkg::RESET_EDGES) begin
                rst_cnt_q <= rst_cnt_q + 2'h1;
            end
            core_rst_q <= (rst_cnt_q == ext_bus_pkg::RESET_EDGES);
        end
    end

    // Bus slave: one wait cycle, then the access completes for one cycle.
    assign bus_req    = avs_read | avs_write;
    assign bus_accept = bus_req && !wait_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wait_q <= 1'b1;
        end else if (bus_req && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Read data is prepared while waitrequest is still high, so it stands
    // at the edge where waitrequest is sampled low.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && wait_q) begin
            unique case (avs_address)
                ext_bus_pkg::LOW_PORT_OFS:
                    avs_readdata <= {24'h0, low_latch_q};
                ext_bus_pkg::HIGH_PORT_OFS:
                    avs_readdata <= {24'h0, high_latch_q};
                ext_bus_pkg::AUX_PORT_OFS:
                    avs_readdata <= {24'h0, aux_latch_q};
                ext_bus_pkg::CLK_CTRL_OFS:
                    avs_readdata <= {30'h0, x2_active, x2_req_q};
                ext_bus_pkg::PIN_READ_OFS:
                    avs_readdata <= {8'h00, aux_port_in, high_port_in,
                                     low_port_in};
                default:
                    avs_readdata <= 32'h0;
            endcase
        end
    end

    // Port latches and the mode bit; the pin reset beats a bus write.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            low_latch_q  <= ext_bus_pkg::PORT_RESET;
            high_latch_q <= ext_bus_pkg::PORT_RESET;
            aux_latch_q  <= ext_bus_pkg::PORT_RESET;
            x2_req_q     <= ext_bus_pkg::X2_REQ_RESET;
        end else if (core_rst_q) begin
            low_latch_q  <= ext_bus_pkg::PORT_RESET;
            high_latch_q <= ext_bus_pkg::PORT_RESET;
            aux_latch_q  <= ext_bus_pkg::PORT_RESET;
            x2_req_q     <= ext_bus_pkg::X2_REQ_RESET;
        end else if (bus_accept && avs_write) begin
            unique case (avs_address)
                ext_bus_pkg::LOW_PORT_OFS:  low_latch_q  <= avs_writedata[7:0];
                ext_bus_pkg::HIGH_PORT_OFS: high_latch_q <= avs_writedata[7:0];
                ext_bus_pkg::AUX_PORT_OFS:  aux_latch_q  <= avs_writedata[7:0];
                ext_bus_pkg::CLK_CTRL_OFS:
                    x2_req_q <= avs_writedata[ext_bus_pkg::X2_REQ_BIT];
                default: ;
            endcase
        end
    end

    // Cycle kind and address chosen at cycle start, external fetch address again at slot B.  A data request is not
    // taken in the cycle its done pulse is still up, which would repeat it.
    always_comb begin
        kind_d = kind_q;
        req_d  = req_q;
        addr_d = addr_q;
        if (cycle_start) begin
            if (xdata_req.valid && !xdata_rsp.done && !core_rst_q) begin
                kind_d = xdata_req.write ? ext_bus_pkg::CYC_DATA_WR
                                         : ext_bus_pkg::CYC_DATA_RD;
                req_d  = xdata_req;
                addr_d = xdata_req.addr;
            end else if (!external_code_select_n && !core_rst_q) begin
                kind_d = ext_bus_pkg::CYC_EXT_FETCH;
                addr_d = fetch_addr;
            end else begin
                kind_d = ext_bus_pkg::CYC_INT_FETCH;
                addr_d = fetch_addr;
            end
        end else if (tick && state_nxt == ext_bus_pkg::ST_ADDR_B &&
                     kind_q == ext_bus_pkg::CYC_EXT_FETCH) begin
            addr_d = fetch_addr;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            kind_q <= ext_bus_pkg::CYC_INT_FETCH;
            req_q  <= '0;
            addr_q <= 16'h0000;
        end else begin
            kind_q <= kind_d;
            req_q  <= req_d;
            addr_q <= addr_d;
        end
    end

    // Strobe and bus view for the state being entered, so pins and state
    // change on the same edge.
    always_comb begin
        ale_d    = 1'b0;
        program_fetch_strobe_n_d = 1'b1;
        rd_n_d   = 1'b1;
        wr_n_d   = 1'b1;
        lp_bus   = 1'b0;
        lp_val   = addr_d[7:0];
        hp_bus   = 1'b0;
        unique case (kind_d)
            ext_bus_pkg::CYC_INT_FETCH: begin
                ale_d = (state_nxt == ext_bus_pkg::ST_ADDR_A) ||
                        (state_nxt == ext_bus_pkg::ST_ADDR_B);
            end
            ext_bus_pkg::CYC_EXT_FETCH: begin
                ale_d    = (state_nxt == ext_bus_pkg::ST_ADDR_A) ||
                           (state_nxt == ext_bus_pkg::ST_ADDR_B);
                program_fetch_strobe_n_d = ale_d;
                lp_bus   = ale_d;
                hp_bus   = 1'b1;
            end
            ext_bus_pkg::CYC_DATA_RD: begin
                ale_d  = (state_nxt == ext_bus_pkg::ST_ADDR_A);
                lp_bus = ale_d;
                rd_n_d = !(state_nxt >= ext_bus_pkg::ST_XFER_FIRST &&
                           state_nxt <= ext_bus_pkg::ST_XFER_LAST);
                hp_bus = req_d.wide;
            end
            ext_bus_pkg::CYC_DATA_WR: begin
                ale_d  = (state_nxt == ext_bus_pkg::ST_ADDR_A);
                lp_bus = 1'b1;
                lp_val = ale_d ? addr_d[7:0] : req_d.wdata;
                wr_n_d = !(state_nxt >= ext_bus_pkg::ST_XFER_FIRST &&
                           state_nxt <= ext_bus_pkg::ST_XFER_LAST);
                hp_bus = req_d.wide;
            end
        endcase
    end

    // Strobes mask the aux latch, so a latch zero still holds the pin low.
    assign aux_eff = aux_latch_q & {rd_n_d, wr_n_d, 6'h3f};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ale                    <= 1'b0;
            program_fetch_strobe_n <= 1'b1;
        end else begin
            ale                    <= ale_d;
            program_fetch_strobe_n <= program_fetch_strobe_n_d;
        end
    end

    // Low port: strong drive of both levels as a bus, else open drain.
    // Outside bus slots of an external cycle the lines float for the read.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            low_port_out  <= 8'h00;
            low_port_oe_n <= 8'hff;
        end else if (lp_bus) begin
            low_port_out  <= lp_val;
            low_port_oe_n <= 8'h00;
        end else begin
            low_port_out  <= 8'h00;
            low_port_oe_n <= (kind_d == ext_bus_pkg::CYC_INT_FETCH)
                             ? low_latch_q : 8'hff;
        end
    end

    // High and aux ports: a latch one releases the pin onto the pull-up.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            high_port_out  <= 8'h00;
            high_port_oe_n <= 8'hff;
            high_port_pull <= 8'hff;
            aux_port_out   <= 8'h00;
            aux_port_oe_n  <= 8'hff;
            aux_port_pull  <= 8'hff;
        end else begin
            if (hp_bus) begin
                high_port_out  <= addr_d[15:8];
                high_port_oe_n <= 8'h00;
                high_port_pull <= 8'h00;
            end else begin
                high_port_out  <= 8'h00;
                high_port_oe_n <= high_latch_q;
                high_port_pull <= high_latch_q;
            end
            aux_port_out  <= 8'h00;
            aux_port_oe_n <= aux_eff;
            aux_port_pull <= aux_eff;
        end
    end

    // Capture at the tick that ends a strobe window; pins have held it
    // for the whole state.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            code_rsp  <= '0;
            xdata_rsp <= '0;
        end else begin
            code_rsp.valid <= tick && kind_q == ext_bus_pkg::CYC_EXT_FETCH &&
                              (state_cur == ext_bus_pkg::ST_FETCH_A ||
                               state_cur == ext_bus_pkg::ST_FETCH_B);
            if (tick && kind_q == ext_bus_pkg::CYC_EXT_FETCH) begin
                code_rsp.data <= low_port_in;
            end
            xdata_rsp.done <= tick &&
                              state_cur == ext_bus_pkg::ST_XFER_LAST &&
                              (kind_q == ext_bus_pkg::CYC_DATA_RD ||
                               kind_q == ext_bus_pkg::CYC_DATA_WR);
            if (tick && state_cur == ext_bus_pkg::ST_XFER_LAST &&
                kind_q == ext_bus_pkg::CYC_DATA_RD) begin
                xdata_rsp.rdata <= low_port_in;
            end
        end
    end

    assign avs_waitrequest = wait_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            core_reset <= 1'b0;
        end else begin
            core_reset <= core_rst_q;
        end
    end

endmodule // ext_bus_ctrl

`default_nettype wire

// file: ext_bus_asserts.sv
/* Pin checks on the bus sequencer.
   Bound from tb_top onto the ports of ext_bus_ctrl. */
`timescale 1ns/1ns
`default_nettype none
module ext_bus_asserts (
    input wire logic       mclk,
    input wire logic       arst_n,
    input wire logic       external_code_select_n,
    input wire logic       ale,
    input wire logic       program_fetch_strobe_n,
    input wire logic [7:0] low_port_oe_n,
    input wire logic [7:0] aux_port_out,
    input wire logic [7:0] aux_port_oe_n
);
    logic wr_on;
    logic rd_on;

    // A strobe is on only while its pin is driven with a zero.
    assign wr_on = !aux_port_oe_n[6] && !aux_port_out[6];
    assign rd_on = !aux_port_oe_n[7] && !aux_port_out[7];

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // A skipped pulse may stretch the spacing to twelve clocks.
    a_ale_rate: assert property (
        $rose(ale) |-> ##1 !$rose(ale) [*2] ##[1:10] $rose(ale))
        else $error("ale spacing");
    // The select is sampled at cycle start, one or two clocks before the first fetch strobe of a cycle.
    a_no_int_fetch: assert property (
        $fell(program_fetch_strobe_n) |->
        !$past(external_code_select_n) || !$past(external_code_select_n, 2))
        else $error("fetch with internal code");
    a_rw_excl: assert property (!(wr_on && rd_on))
        else $error("read and write together");
    a_rw_no_fetch: assert property (
        (wr_on || rd_on) |-> program_fetch_strobe_n)
        else $error("fetch in data access");
    a_rw_no_ale: assert property ((wr_on || rd_on) |-> !ale)
        else $error("ale in data access");
    a_rw_len: assert property (
        $rose(wr_on || rd_on) |-> (wr_on || rd_on) [*4])
        else $error("short data strobe");
    a_wr_drive: assert property (wr_on |-> low_port_oe_n == 8'h00)
        else $error("low port idle in write");
    a_rd_float: assert property (rd_on |-> low_port_oe_n == 8'hff)
        else $error("low port driven in read");

    c_fetch: cover property ($fell(program_fetch_strobe_n));
    c_read: cover property ($rose(rd_on));
    c_write: cover property ($rose(wr_on));
endmodule // ext_bus_asserts
`default_nettype wire

// file: ext_mem_model.sv
/* External address latch with code and data memories.
   Assumes low strobes and no pull-up on the low port. */
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
    input  wire logic       mclk,
    input  wire logic       ale,
    input  wire logic       fetch_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] bus_in,
    input  wire logic [7:0] addr_hi,
    output logic      [7:0] bus_out
);
    logic [7:0] lat_q;
    logic [7:0] last_q;
    logic [7:0] mem_q [256];

    // Latch follows the bus while ale is high; writes land each clock
    // the strobe is low, so the last data wins.
    always_ff @(posedge mclk) begin
        last_q <= bus_in;
        if (ale) begin
            lat_q <= bus_in;
        end
        if (!wr_n) begin
            mem_q[lat_q] <= bus_in;
        end
    end

    // Code mixes both address halves, so a wrong high byte shows.
    // A released bus shows the inverse of its last level.
    always_comb begin
        if (!fetch_n) begin
            bus_out = lat_q ^ addr_hi ^ 8'h5a;
        end else if (!rd_n) begin
            bus_out = mem_q[lat_q];
        end else begin
            bus_out = ~last_q;
        end
    end
endmodule // ext_mem_model
`default_nettype wire

// file: tb_top.sv
/* Self-checking bench for ext_bus_ctrl and a memory model.
   Assumes package, design and model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic                    mclk, arst_n, reset_pin, sel_n, ale, fetch_n;
    logic                    core_reset, av_rd, av_wr, av_wait;
    logic [7:0]              low_out, low_oe, high_out, high_oe, high_pull;
    logic [7:0]              aux_out, aux_oe, aux_pull, low_w, high_w, aux_w;
    logic [7:0]              mem_out, av_addr;
    logic [15:0]             fetch_addr;
    logic [31:0]             av_wd, av_rdata, rd;
    ext_bus_pkg::xdata_req_t req;
    ext_bus_pkg::xdata_rsp_t rsp;
    ext_bus_pkg::code_rsp_t  code;
    int                      fails, cmp_count;

    // Driven value first, then the pull-up, then the memory side.
    assign low_w = (low_out & ~low_oe) | (mem_out & low_oe);
    assign high_w = (high_out & ~high_oe) | (high_pull & high_oe);
    assign aux_w = (aux_out & ~aux_oe) | (aux_pull & aux_oe);

    ext_bus_ctrl dut_u (
        .mclk(mclk), .arst_n(arst_n), .reset_pin(reset_pin),
        .external_code_select_n(sel_n), .fetch_addr(fetch_addr),
        .xdata_req(req), .xdata_rsp(rsp), .code_rsp(code),
        .core_reset(core_reset), .ale(ale), .program_fetch_strobe_n(fetch_n),
        .low_port_in(low_w), .low_port_out(low_out), .low_port_oe_n(low_oe),
        .high_port_in(high_w), .high_port_out(high_out),
        .high_port_oe_n(high_oe), .high_port_pull(high_pull),
        .aux_port_in(aux_w), .aux_port_out(aux_out),
        .aux_port_oe_n(aux_oe), .aux_port_pull(aux_pull),
        .avs_address(av_addr), .avs_read(av_rd), .avs_write(av_wr),
        .avs_writedata(av_wd), .avs_readdata(av_rdata),
        .avs_waitrequest(av_wait)
    );

    ext_mem_model mem_u (
        .mclk(mclk), .ale(ale), .fetch_n(fetch_n), .rd_n(aux_w[7]),
        .wr_n(aux_w[6]), .bus_in(low_w), .addr_hi(high_w), .bus_out(mem_out)
    );

    // Free-running oscillator.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic end_sim();
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    // A wait that ran out is a mismatch and ends the run.
    task automatic tmo(input logic ok);
        if (!ok) begin
            fails++;
            end_sim();
        end
    endtask

    // One access; the request holds until waitrequest is low.
    task automatic av(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        av_addr <= a;
        av_wr <= w;
        av_rd <= !w;
        av_wd <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (av_wait !== 1'b0 && n < 40);
        rd = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        tmo(av_wait === 1'b0);
    endtask

    // Counts ale rises and fetch strobe falls over 24 settled clocks.
    task automatic count(output int a, output int p);
        logic la, lp;
        a = 0;
        p = 0;
        repeat (12) @(posedge mclk);
        la = ale;
        lp = fetch_n;
        repeat (24) begin
            @(posedge mclk);
            if (ale === 1'b1 && la === 1'b0) a++;
            if (fetch_n === 1'b0 && lp === 1'b1) p++;
            la = ale;
            lp = fetch_n;
        end
    endtask

    // Data access; s keeps strobe and high port pins seen.
    task automatic xfer(input logic w, input logic wide,
                        input logic [15:0] ad, input logic [7:0] wd,
                        output logic [9:0] s, output logic [7:0] rv);
        int n = 0;
        s = 'x;
        @(posedge mclk);
        req <= '{1'b1, w, wide, ad, wd};
        do begin
            @(posedge mclk);
            n++;
            if (aux_w[7:6] !== 2'b11) s = {aux_w[7:6], high_w};
        end while (rsp.done !== 1'b1 && n < 80);
        rv = rsp.rdata;
        req.valid <= 1'b0;
        tmo(rsp.done === 1'b1);
    endtask

    task automatic t_regs();
        logic [7:0] ofs [3];
        ofs = '{ext_bus_pkg::LOW_PORT_OFS, ext_bus_pkg::HIGH_PORT_OFS,
                ext_bus_pkg::AUX_PORT_OFS};
        foreach (ofs[i]) begin
            av(1'b0, ofs[i], 32'h0);
            chk("latch reset", 32'hff, rd);
        end
        av(1'b0, ext_bus_pkg::CLK_CTRL_OFS, 32'h0);
        chk("clock ctrl reset", 32'h0, rd);
        av(1'b1, 8'h90, 32'h55);
        av(1'b0, 8'h90, 32'h0);
        chk("unmapped", 32'h0, rd);
        av(1'b1, ext_bus_pkg::HIGH_PORT_OFS, 32'h12);
        av(1'b1, ext_bus_pkg::AUX_PORT_OFS, 32'hcf);
        repeat (4) @(posedge mclk);
        av(1'b0, ext_bus_pkg::PIN_READ_OFS, 32'h0);
        chk("aux high pins", 32'hcf12, {16'h0, rd[23:8]});
        av(1'b1, ext_bus_pkg::AUX_PORT_OFS, 32'hff);
    endtask

    task automatic t_int();
        int a, p;
        count(a, p);
        chk("ale rises", 32'd4, a);
        chk("fetch internal", 32'd0, p);
        av(1'b1, ext_bus_pkg::LOW_PORT_OFS, 32'h0f);
        repeat (4) @(posedge mclk);
        chk("low enables", 32'h0f, {24'h0, low_oe});
        av(1'b1, ext_bus_pkg::LOW_PORT_OFS, 32'hff);
    endtask

    task automatic t_ext();
        int a, p;
        logic [7:0] d;
        @(posedge mclk);
        sel_n <= 1'b0;
        fetch_addr <= 16'h3c5a;
        do begin
            @(posedge mclk);
            a++;
        end while (code.valid !== 1'b1 && a < 60);
        d = code.data;
        tmo(code.valid === 1'b1);
        chk("code byte", 32'h3c, {24'h0, d});
        count(a, p);
        chk("ale rises ext", 32'd4, a);
        chk("fetch falls", 32'd4, p);
    endtask

    task automatic t_data();
        logic [9:0] s;
        logic [7:0] rv;
        xfer(1'b1, 1'b1, 16'hc3a5, 8'h96, s, rv);
        chk("wide write pins", 32'h2c3, {22'h0, s});
        xfer(1'b0, 1'b0, 16'h00a5, 8'h00, s, rv);
        chk("narrow read pins", 32'h112, {22'h0, s});
        chk("read back", 32'h96, {24'h0, rv});
    endtask

    task automatic t_fast();
        int a, p;
        logic [9:0] s;
        logic [7:0] rv;
        av(1'b1, ext_bus_pkg::CLK_CTRL_OFS, 32'h1);
        repeat (8) @(posedge mclk);
        av(1'b0, ext_bus_pkg::CLK_CTRL_OFS, 32'h0);
        chk("mode active", 32'h3, rd);
        count(a, p);
        chk("ale rises fast", 32'd8, a);
        chk("fetch falls fast", 32'd8, p);
        xfer(1'b0, 1'b1, 16'hc3a5, 8'h00, s, rv);
        chk("fast read", 32'h96, {24'h0, rv});
        av(1'b1, ext_bus_pkg::CLK_CTRL_OFS, 32'h0);
        count(a, p);
        chk("ale rises slow", 32'd4, a);
    endtask

    task automatic t_rst();
        @(posedge mclk);
        reset_pin <= 1'b1;
        repeat (12) @(posedge mclk);
        chk("reset too short", 32'h0, {31'h0, core_reset});
        repeat (36) @(posedge mclk);
        chk("core reset", 32'h1, {31'h0, core_reset});
        av(1'b0, ext_bus_pkg::HIGH_PORT_OFS, 32'h0);
        chk("latch after reset", 32'hff, rd);
        reset_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("reset ends", 32'h0, {31'h0, core_reset});
    endtask

    // Reset, then the scenarios; internal code first.
    initial begin
        fails = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        reset_pin = 1'b0;
        sel_n = 1'b1;
        fetch_addr = 16'h0;
        req = '0;
        av_addr = 8'h0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_wd = 32'h0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs();
        t_int();
        t_ext();
        t_data();
        t_fast();
        t_rst();
        end_sim();
    end
endmodule // tb_top

bind ext_bus_ctrl ext_bus_asserts chk_u (
    .mclk, .arst_n, .external_code_select_n, .ale, .program_fetch_strobe_n,
    .low_port_oe_n, .aux_port_out, .aux_port_oe_n
);
`default_nettype wire
